// ==== include/fwsr_pkg.sv ====
// fwsr_pkg: constants, operation codes and pin bundle of the flash status controller.
// assumes a byte-wide parallel flash on the far side of the pins and a 40 MHz pclk.
package fwsr_pkg;

  // clock and bus-cycle timing
  localparam int CLK_PS = 25000;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 50;
  localparam int POLL_GAP_NS = 1000;
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] GAP_CYC = 8'((POLL_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // apb register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_CMD = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;

  // status register field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY = 3;
  localparam int ST_ETMR = 4;
  localparam int ST_TGL2 = 5;
  localparam int ST_SUSP = 6;
  localparam int ST_RDATA = 8;

  // ctrl field: 0 data polling, 1 toggle polling
  localparam int CTRL_TOGGLE = 0;

  // operation codes written to the command register
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_CHIP = 3'h2;
  localparam logic [2:0] OP_SECT = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;

  // flash data bit positions
  localparam int DQ_POLL = 7;
  localparam int DQ_TGL1 = 6;
  localparam int DQ_TOUT = 5;
  localparam int DQ_ETMR = 3;
  localparam int DQ_TGL2 = 2;

  // command-sequence words
  localparam logic [19:0] UNLOCK_A1 = 20'h00555;
  localparam logic [19:0] UNLOCK_A2 = 20'h002AA;
  localparam logic [7:0] UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERSETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [2:0] LEN_PROG = 3'h4;
  localparam logic [2:0] LEN_ERASE = 3'h6;
  localparam logic [2:0] LEN_RESET = 3'h1;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
  } fwsr_pins_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
  } fwsr_word_s;

endpackage

// ==== hdl/fwsr_bus_cycle.sv ====
// fwsr_bus_cycle: one asynchronous read or write cycle on the flash pins.
// assumes the flash answers within STROBE_CYC cycles of the strobe falling.
`timescale 1ns/1ps
module fwsr_bus_cycle import fwsr_pkg::*; (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low active
  input wire logic clk_en, // freezes all state while low
  input wire logic start, // begin a cycle, taken while idle
  input wire logic is_write, // 1 write, 0 read
  input wire fwsr_word_s word, // address and write data
  input wire logic [7:0] dq_in, // data from flash
  output fwsr_pins_s pins, // flash pin bundle
  output logic done, // one-cycle pulse at end of cycle
  output logic [7:0] rdata // data sampled at end of read strobe
);
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fwsr_bc_e;

  fwsr_bc_e state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BC_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0};
      done <= 1'b0;
      rdata <= 8'h00;
    end else if (clk_en) begin
      done <= 1'b0;
      case (state_reg)
        BC_IDLE: begin
          if (start) begin
            wr_reg <= is_write;
            pins.addr <= word.addr;
            pins.dq_out <= word.data;
            pins.dq_oe <= is_write;
            pins.ce_n <= 1'b0;
            state_reg <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          pins.oe_n <= wr_reg;
          pins.we_n <= !wr_reg;
          cnt_reg <= STROBE_CYC;
          state_reg <= BC_STROBE;
        end
        BC_STROBE: begin
          if (cnt_reg == 8'h01) begin
            // write data is latched by the flash on this rising strobe
            if (!wr_reg) begin
              rdata <= dq_in;
            end
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            cnt_reg <= HOLD_CYC;
            state_reg <= BC_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        BC_HOLD: begin
          if (cnt_reg == 8'h01) begin
            pins.ce_n <= 1'b1;
            pins.dq_oe <= 1'b0;
            done <= 1'b1;
            state_reg <= BC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= BC_IDLE;
      endcase
    end
  end
endmodule // fwsr_bus_cycle

// ==== hdl/fwsr_top.sv ====
// fwsr_top: host controller that issues program/erase sequences to a parallel flash
// and runs the data-polling or toggle-bit algorithm until the operation settles.
// assumes an apb master on the register side and a byte-mode flash on the pins.
// Operation
// - poll inside the target sector only
// - reread after poll match for valid byte
// - after timeout bit, recheck toggle bit
// - read whole byte twice to judge toggling
// - still toggling with timeout means fail, reset
// - restart double read after leaving monitoring
// - combine both toggle bits for suspend info
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module fwsr_top import fwsr_pkg::*; (
  input wire logic pclk, // 40 MHz clock
  input wire logic presetn, // async reset, low active
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output fwsr_pins_s flash_pins, // flash strobes, address and data drive
  input wire logic [7:0] flash_dq_in, // flash data inputs
  input wire logic ready_busy_n // flash ready/busy, low while busy
);
  typedef enum logic [2:0] {S_IDLE, S_SEQ, S_RD_A, S_RD_B, S_JUDGE, S_GAP} fwsr_state_e;

  fwsr_state_e state_reg;
  logic ctrl_toggle_reg;
  logic [19:0] addr_reg;
  logic [7:0] data_reg;
  logic [2:0] op_reg;
  logic [2:0] seq_op_reg;
  logic [2:0] idx_reg;
  logic issued_reg;
  logic recheck_reg;
  logic confirm_reg;
  logic [7:0] rd_a_reg;
  logic [7:0] rd_b_reg;
  logic [7:0] gap_reg;
  logic done_reg;
  logic fail_reg;
  logic etmr_reg;
  logic tgl2_reg;
  logic susp_reg;
  logic rdy_reg;

  // sequence table: one word per bus write, per operation
  function automatic fwsr_word_s seq_word(input logic [2:0] op, input logic [2:0] idx,
                                          input logic [19:0] a, input logic [7:0] d);
    fwsr_word_s w;
    w = '{addr: UNLOCK_A1, data: UNLOCK_D1};
    if (op == OP_RESET) begin
      w.data = CMD_RESET;
    end else begin
      case (idx)
        3'h1: w = '{addr: UNLOCK_A2, data: UNLOCK_D2};
        3'h2: w.data = (op == OP_PROG) ? CMD_PROG : CMD_ERSETUP;
        3'h3: begin
          if (op == OP_PROG) begin
            w = '{addr: a, data: d};
          end
        end
        3'h4: w = '{addr: UNLOCK_A2, data: UNLOCK_D2};
        3'h5: begin
          if (op == OP_SECT) begin
            w = '{addr: a, data: CMD_SECT};
          end else begin
            w.data = CMD_CHIP;
          end
        end
        default: w = '{addr: UNLOCK_A1, data: UNLOCK_D1};
      endcase
    end
    return w;
  endfunction

  function automatic logic [2:0] seq_len(input logic [2:0] op);
    return (op == OP_PROG) ? LEN_PROG : (op == OP_RESET) ? LEN_RESET : LEN_ERASE;
  endfunction

  // apb decode
  wire apb_acc = psel && penable && !pready;
  wire apb_fin = psel && penable && pready;
  wire wr_fin = apb_fin && pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_addr = paddr == OFS_ADDR;
  wire hit_data = paddr == OFS_DATA;
  wire hit_cmd = paddr == OFS_CMD;
  wire hit_stat = paddr == OFS_STATUS;
  wire mapped = hit_ctrl || hit_addr || hit_data || hit_cmd || hit_stat;
  wire busy = state_reg != S_IDLE;
  wire [2:0] cmd_op = pwdata[2:0];
  wire cmd_ok = (cmd_op == OP_PROG) || (cmd_op == OP_CHIP) || (cmd_op == OP_SECT) ||
                (cmd_op == OP_RESET);
  // a command while busy is dropped; done/fail stay until the next accepted command
  wire cmd_go = wr_fin && hit_cmd && !busy && cmd_ok;

  wire [31:0] status_word = {16'h0000, (state_reg == S_IDLE) ? rd_b_reg : rd_a_reg, 1'b0,
                             susp_reg, tgl2_reg, etmr_reg, rdy_reg, fail_reg, done_reg, busy};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_toggle_reg} :
                       hit_addr ? {12'h000, addr_reg} :
                       hit_data ? {24'h000000, data_reg} :
                       hit_cmd ? {29'h0, op_reg} :
                       hit_stat ? status_word : 32'h00000000;

  // flash bus-cycle engine
  wire in_read = (state_reg == S_RD_A) || (state_reg == S_RD_B);
  wire bc_start = (state_reg == S_SEQ || in_read) && !issued_reg;
  wire bc_done;
  wire [7:0] bc_rdata;
  // polling stays at the target address so the status comes from the busy sector
  wire fwsr_word_s bc_word = in_read ? fwsr_word_s'{addr: addr_reg, data: 8'h00} :
                              seq_word(seq_op_reg, idx_reg, addr_reg, data_reg);

  fwsr_bus_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .start(bc_start),
    .is_write(state_reg == S_SEQ),
    .word(bc_word),
    .dq_in(flash_dq_in),
    .pins(flash_pins),
    .done(bc_done),
    .rdata(bc_rdata)
  );

  // judging the collected reads
  wire expect_bit = (op_reg == OP_PROG) ? data_reg[DQ_POLL] : 1'b1;
  wire poll_match = rd_a_reg[DQ_POLL] == expect_bit;
  wire tgl1_flip = rd_a_reg[DQ_TGL1] ^ rd_b_reg[DQ_TGL1];
  wire tgl2_flip = rd_a_reg[DQ_TGL2] ^ rd_b_reg[DQ_TGL2];
  wire settled = ctrl_toggle_reg ? !tgl1_flip : poll_match;
  wire tout_seen = ctrl_toggle_reg ? rd_b_reg[DQ_TOUT] : rd_a_reg[DQ_TOUT];
  wire seq_last = idx_reg == seq_len(seq_op_reg) - 3'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= apb_acc;
      pslverr <= apb_acc && !mapped;
      if (apb_acc) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_toggle_reg <= 1'b0;
      addr_reg <= 20'h00000;
      data_reg <= 8'h00;
      rdy_reg <= 1'b1;
    end else if (clk_en) begin
      // ready/busy follows the flash from the final write strobe onward
      rdy_reg <= ready_busy_n;
      if (wr_fin && hit_ctrl) begin
        ctrl_toggle_reg <= pwdata[CTRL_TOGGLE];
      end
      if (wr_fin && hit_addr && !busy) begin
        addr_reg <= pwdata[19:0];
      end
      if (wr_fin && hit_data && !busy) begin
        data_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      op_reg <= OP_NONE;
      seq_op_reg <= OP_NONE;
      idx_reg <= 3'h0;
      issued_reg <= 1'b0;
      recheck_reg <= 1'b0;
      confirm_reg <= 1'b0;
      rd_a_reg <= 8'h00;
      rd_b_reg <= 8'h00;
      gap_reg <= 8'h00;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      etmr_reg <= 1'b0;
      tgl2_reg <= 1'b0;
      susp_reg <= 1'b0;
    end else if (clk_en) begin
      if (bc_start) begin
        issued_reg <= 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_go) begin
            op_reg <= cmd_op;
            seq_op_reg <= cmd_op;
            idx_reg <= 3'h0;
            issued_reg <= 1'b0;
            recheck_reg <= 1'b0;
            confirm_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            etmr_reg <= 1'b0;
            tgl2_reg <= 1'b0;
            susp_reg <= 1'b0;
            state_reg <= S_SEQ;
          end
        end
        S_SEQ: begin
          if (bc_done) begin
            issued_reg <= 1'b0;
            idx_reg <= idx_reg + 3'h1;
            if (seq_last) begin
              // reset sequence, plain or after a failure, finishes without polling
              if (seq_op_reg == OP_RESET) begin
                done_reg <= 1'b1;
                state_reg <= S_IDLE;
              end else begin
                state_reg <= S_RD_A;
              end
            end
          end
        end
        S_RD_A: begin
          if (bc_done) begin
            issued_reg <= 1'b0;
            rd_a_reg <= bc_rdata;
            state_reg <= ctrl_toggle_reg ? S_RD_B : S_JUDGE;
          end
        end
        S_RD_B: begin
          if (bc_done) begin
            issued_reg <= 1'b0;
            rd_b_reg <= bc_rdata;
            if (confirm_reg) begin
              // only this second read carries a valid byte on all eight bits
              done_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_JUDGE;
            end
          end
        end
        S_JUDGE: begin
          if (op_reg == OP_SECT && rd_a_reg[DQ_ETMR]) begin
            etmr_reg <= 1'b1;
          end
          if (ctrl_toggle_reg && tgl2_flip) begin
            tgl2_reg <= 1'b1;
            susp_reg <= susp_reg | !tgl1_flip;
          end
          if (settled) begin
            // also covers a protected target: toggling stops after a short burst
            // the settling read may carry stale low bits, so one more read follows
            confirm_reg <= 1'b1;
            state_reg <= S_RD_B;
          end else if (recheck_reg) begin
            // still busy after the timeout bit: give up and reset the flash
            fail_reg <= 1'b1;
            seq_op_reg <= OP_RESET;
            idx_reg <= 3'h0;
            state_reg <= S_SEQ;
          end else if (tout_seen) begin
            recheck_reg <= 1'b1;
            state_reg <= S_RD_A;
          end else begin
            gap_reg <= GAP_CYC;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          // after idling, a fresh read (a fresh pair in toggle mode) is taken, never a stale one
          if (gap_reg == 8'h01) begin
            state_reg <= S_RD_A;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // fwsr_top

// ==== verification/fwsr_top_sva.sv ====
// fwsr_top_sva: port-level checks of the flash status controller.
// assumes clk_en held high, so every edge is an active edge.
`timescale 1ns/1ps
module fwsr_top_sva import fwsr_pkg::*; (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire fwsr_pins_s flash_pins // flash pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_rdy_cause; pready |-> $past(psel) && $past(penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access phase");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");
  property p_no_dual; !(!flash_pins.oe_n && !flash_pins.we_n); endproperty
  a_no_dual: assert property (p_no_dual) else $error("read and write strobes both low");
  property p_ce_frame; (!flash_pins.oe_n || !flash_pins.we_n) |-> !flash_pins.ce_n; endproperty
  a_ce_frame: assert property (p_ce_frame) else $error("strobe low outside chip enable");
  // host must not fight the flash while it drives status
  property p_rd_float; !flash_pins.oe_n |-> !flash_pins.dq_oe; endproperty
  a_rd_float: assert property (p_rd_float) else $error("data driven during read");
  property p_rd_addr; !flash_pins.oe_n |-> $stable(flash_pins.addr); endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("poll address moved in read");
  property p_wr_len;
    $fell(flash_pins.we_n) |-> (!flash_pins.we_n)[*4] ##1 flash_pins.we_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe not four cycles");
  property p_wr_data; !flash_pins.we_n |-> flash_pins.dq_oe && $stable(flash_pins.dq_out);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not held");

  c_write: cover property ($fell(flash_pins.we_n));
  c_read: cover property ($fell(flash_pins.oe_n));
  c_err: cover property (pslverr);
endmodule // fwsr_top_sva

bind fwsr_top fwsr_top_sva fwsr_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins));

// ==== verification/fwsr_flash_model.sv ====
// fwsr_flash_model: behavioural byte flash that reports program/erase status.
// assumes the bench resolves ready/busy with a pull-up; no array, one target byte.
`timescale 1ns/1ps
module fwsr_flash_model import fwsr_pkg::*; (
  input wire fwsr_pins_s pins, // controller pins
  input wire logic [7:0] busy_reads, // reads that still see busy status
  input wire logic fail_mode, // never completes, error bit set
  output logic [7:0] dq, // data towards controller
  output logic rb_pull // pulls ready/busy low while high
);
  logic [1:0] op; // 0 idle, 1 program, 2 erase
  logic [7:0] pd, prev, left, last, val;
  logic t1, t2, tout, etmr, fresh;
  initial begin
    op = 2'h0; pd = 8'hFF; prev = 8'h00; left = 8'h00; last = 8'h00;
    {t1, t2, tout, etmr, fresh} = 5'h00;
  end
  always @(posedge pins.we_n) begin
    if (op == 2'h0 && (prev == CMD_PROG || (prev == UNLOCK_D2 &&
        (pins.dq_out == CMD_CHIP || pins.dq_out == CMD_SECT)))) begin
      op = (prev == CMD_PROG) ? 2'h1 : 2'h2;
      pd = (prev == CMD_PROG) ? pins.dq_out : 8'hFF;
      etmr = (prev != CMD_PROG) && (pins.dq_out == CMD_SECT);
      left = busy_reads;
      tout = fail_mode;
      fresh = 1'b0;
    end else if (pins.dq_out == CMD_RESET && (op == 2'h0 || tout)) begin
      op = 2'h0;
      tout = 1'b0;
    end
    prev = pins.dq_out;
  end
  // busy status: program shows inverted bit, erase shows 0
  // first completion read: some low bits stale, toggle bits already settled
  assign val = (op == 2'h0) ? (fresh ? (pd ^ 8'h1B) : pd)
    : {(op == 2'h1) ? ~pd[7] : 1'b0, t1, tout, 1'b0, etmr,
       (op == 2'h2) ? t2 : 1'b0, 2'h0};
  // released bus shows the inverse, never a stale match
  assign dq = (!pins.ce_n && !pins.oe_n) ? val : ~last;
  assign rb_pull = (op != 2'h0);
  always @(posedge pins.oe_n) begin
    last = val;
    prev = 8'h00;
    fresh = 1'b0;
    if (op != 2'h0) begin
      t1 = ~t1;
      t2 = ~t2;
      if (left > 8'h01) left = left - 8'h01; // bounded toggling
      else if (!tout) begin
        op = 2'h0;
        fresh = 1'b1; // low bits not yet valid on first completion read
      end
    end
  end
endmodule // fwsr_flash_model

// ==== verification/fwsr_bench.sv ====
// fwsr_bench: self-checking bench of the flash status controller over apb.
// assumes fwsr_flash_model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
module fwsr_bench import fwsr_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rb_pull, fail_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] dq, busy_reads;
  fwsr_pins_s flash_pins;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'h596d;
  wire logic ready_busy_n = rb_pull ? 1'b0 : 1'b1;

  fwsr_top fwsr_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins), .flash_dq_in(dq),
    .ready_busy_n(ready_busy_n));
  fwsr_flash_model fwsr_flash_model_inst (.pins(flash_pins), .busy_reads(busy_reads),
    .fail_mode(fail_mode), .dq(dq), .rb_pull(rb_pull));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic logic [7:0] exp_byte(input logic [2:0] op, input logic [7:0] d);
    return (op == OP_PROG) ? d : 8'hFF;
  endfunction

  initial begin
    logic [31:0] r;
    logic e;
    logic [7:0] d;
    logic [2:0] op;
    logic fl;
    logic sb;
    int i, k;
    {psel, penable, pwrite, presetn, fail_mode} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0000_0000; busy_reads = 8'h01;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0, r, e);
    chk(r[ST_BUSY], 1'b0);
    chk(r[ST_RDY], 1'b1);
    apb(1'b0, 12'h0FC, 32'h0, r, e);
    chk(e, 1'b1);
    for (i = 0; i < 8; i++) begin
      op = (i < 2 || i > 5) ? OP_PROG : ((i < 4) ? OP_CHIP : OP_SECT);
      fl = (i > 5);
      d = $random(seed);
      // erase needs two busy reads so a toggle pair can show toggle bit two
      busy_reads <= (i == 0) ? 8'h01 : ((i == 1) ? 8'h08 : 8'h02 + 8'($random(seed) & 7));
      fail_mode <= fl;
      apb(1'b1, OFS_CTRL, 32'(i % 2), r, e);
      apb(1'b1, OFS_ADDR, 32'($random(seed) & 32'h000F_FFFF), r, e);
      apb(1'b1, OFS_DATA, {24'h0, d}, r, e);
      apb(1'b1, OFS_CMD, {29'h0, op}, r, e);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
      chk(r[ST_BUSY], 1'b1);
      // command and data changes while busy must be dropped
      apb(1'b1, OFS_CMD, {29'h0, OP_RESET}, r, e);
      apb(1'b1, OFS_DATA, {24'h0, ~d}, r, e);
      k = 0;
      sb = 1'b0;
      do begin
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        if (r[ST_RDY] === 1'b0) sb = 1'b1;
        k++;
      end while (r[ST_DONE] !== 1'b1 && k < 3000);
      if (k >= 3000) begin
        n_mismatch++;
        complete_run();
      end
      chk(r[ST_FAIL], fl);
      if (!fl) chk(r[15:8], exp_byte(op, d));
      chk(r[ST_ETMR], op == OP_SECT);
      chk(r[ST_TGL2], (op != OP_PROG) && (i % 2 == 1));
      chk(r[ST_SUSP], 1'b0);
      chk(sb, 1'b1);
      chk(r[ST_BUSY], 1'b0);
      chk(r[ST_RDY], 1'b1);
      apb(1'b0, OFS_CMD, 32'h0, r, e);
      chk(r[2:0], op);
      $display("test %0d op %0d mode %0d done", i, op, i % 2);
    end
    apb(1'b1, OFS_CMD, 32'h0000_0005, r, e);
    apb(1'b0, OFS_STATUS, 32'h0, r, e);
    chk(r[ST_BUSY], 1'b0);
    $display("test invalid op done");
    complete_run();
  end
endmodule // fwsr_bench
